//--- pkg/startup_cfg_map.svh
// Purpose: Offsets, field positions, reset values and timing figures.
// Assumes: 32-bit registers on a plain byte-addressed port, four bytes apart.
// Notes:   Only definitions live here.
`ifndef STARTUP_CFG_MAP_SVH
`define STARTUP_CFG_MAP_SVH

`define ADDR_W                  8
`define OFS_STARTUP_TWO         8'h84
`define OFS_CLOSED_LOOP_ONE     8'h88
`define OFS_RAMP_STATUS         8'h8C

`define RST_STARTUP_TWO         32'h0000_0000
`define RST_CLOSED_LOOP_ONE     32'h0000_0000

// Start-up word, low part.
`define ALIGN_ANGLE_MSB         12
`define ALIGN_ANGLE_LSB         8
`define FIRST_PCT_MSB           7
`define FIRST_PCT_LSB           4
`define FIRST_SEL_BIT           3
`define RAMP_RATE_MSB           2
`define RAMP_RATE_LSB           0
`define ALIGN_LAST_VALID        5'h1C

// Closed-loop word.
`define CL_RSVD_BIT             31
`define CL_OVERMOD_BIT          30
`define CL_ACCEL_MSB            29
`define CL_ACCEL_LSB            25
`define CL_DECEL_SRC_BIT        24
`define CL_DECEL_MSB            23
`define CL_DECEL_LSB            19
`define CL_PWM_FREQ_MSB         18
`define CL_PWM_FREQ_LSB         15
`define CL_PWM_MODE_BIT         14
`define CL_SP_SEL_MSB           13
`define CL_SP_SEL_LSB           12
`define CL_SP_DIV_MSB           11
`define CL_SP_DIV_LSB           8
`define CL_SP_CFG_BIT           7
`define CL_SP_BEMF_MSB          6
`define CL_SP_BEMF_LSB          4
`define CL_SURGE_BIT            3
`define CL_DEADCOMP_BIT         2
`define CL_VLOOP_OFF_BIT        1
`define CL_RECIRC_BIT           0

// Ramp status word.
`define ST_BUSY_BIT             16
`define ST_GAP_MSB              15
`define ST_GAP_LSB              0

// Timing: one ramp step each millisecond.
`define CLK_PERIOD_NS           20
`define RAMP_STEP_NS            1000000
`define PCT_SCALE               1000

`endif

//--- pkg/startup_cfg_pkg.sv
// Purpose: Types shared by the configuration bank and its decoder.
// Assumes: Constants come from startup_cfg_map.svh.
// Notes:   Percentages are in tenths, angles in degrees.
package startup_cfg_pkg;

   typedef enum logic [1:0] {
      start_slow_cycle   = 2'b00,
      start_align        = 2'b01,
      start_double_align = 2'b11,
      start_init_pos     = 2'b10
   } startup_mode_t;

   typedef enum logic [1:0] {
      ramp_idle = 2'b00,
      ramp_run  = 2'b01,
      ramp_hold = 2'b11
   } ramp_state_t;

   typedef logic [8:0]  angle_deg_t;
   typedef logic [9:0]  pct_tenth_t;
   typedef logic [7:0]  rate_centi_t;

endpackage

//--- pkg/cfg_field_if.sv
// Purpose: Carries raw start-up fields to the decoder and meanings back.
// Assumes: Single clock, purely combinational decode.
// Notes:   None.
`timescale 1ns/1ns
interface cfg_field_if;
   import startup_cfg_pkg::*;
   logic [4:0]   align_code;
   logic [3:0]   pct_code;
   logic [2:0]   rate_code;
   angle_deg_t   angle_deg;
   logic         angle_reserved;
   pct_tenth_t   pct_tenth;
   rate_centi_t  rate_centi;

   modport bank (output align_code, pct_code, rate_code,
                 input  angle_deg, angle_reserved, pct_tenth, rate_centi);
   modport decoder (input  align_code, pct_code, rate_code,
                    output angle_deg, angle_reserved, pct_tenth,
                           rate_centi);
endinterface

//--- hdl/startup_field_decode.sv
// Purpose: Turns start-up field codes into angles, percentages and rates.
// Assumes: Codes come straight from the start-up register.
// Notes:   Purely combinational lookup tables.
`timescale 1ns/1ns
`include "startup_cfg_map.svh"
module startup_field_decode
   import startup_cfg_pkg::*;
(
   cfg_field_if.decoder f
);

   function automatic angle_deg_t angle_of(input logic [4:0] c);
      case (c)
         5'h00: angle_of = 9'h000;
         5'h01: angle_of = 9'h00A;
         5'h02: angle_of = 9'h014;
         5'h03: angle_of = 9'h01E;
         5'h04: angle_of = 9'h02D;
         5'h05: angle_of = 9'h03C;
         5'h06: angle_of = 9'h046;
         5'h07: angle_of = 9'h050;
         5'h08: angle_of = 9'h05A;
         5'h09: angle_of = 9'h06E;
         5'h0A: angle_of = 9'h078;
         5'h0B: angle_of = 9'h087;
         5'h0C: angle_of = 9'h096;
         5'h0D: angle_of = 9'h0A0;
         5'h0E: angle_of = 9'h0AA;
         5'h0F: angle_of = 9'h0B4;
         5'h10: angle_of = 9'h0BE;
         5'h11: angle_of = 9'h0D2;
         5'h12: angle_of = 9'h0E1;
         5'h13: angle_of = 9'h0F0;
         5'h14: angle_of = 9'h0FA;
         5'h15: angle_of = 9'h104;
         5'h16: angle_of = 9'h10E;
         5'h17: angle_of = 9'h118;
         5'h18: angle_of = 9'h122;
         5'h19: angle_of = 9'h13B;
         5'h1A: angle_of = 9'h14A;
         5'h1B: angle_of = 9'h154;
         5'h1C: angle_of = 9'h15E;
         default: angle_of = 9'h000;
      endcase
   endfunction

   function automatic pct_tenth_t pct_of(input logic [3:0] c);
      case (c)
         4'h0: pct_of = 10'h00A;
         4'h1: pct_of = 10'h014;
         4'h2: pct_of = 10'h01E;
         4'h3: pct_of = 10'h032;
         4'h4: pct_of = 10'h04B;
         4'h5: pct_of = 10'h064;
         4'h6: pct_of = 10'h07D;
         4'h7: pct_of = 10'h096;
         4'h8: pct_of = 10'h0AF;
         4'h9: pct_of = 10'h0C8;
         4'hA: pct_of = 10'h0FA;
         4'hB: pct_of = 10'h12C;
         4'hC: pct_of = 10'h15E;
         4'hD: pct_of = 10'h190;
         4'hE: pct_of = 10'h1C2;
         default: pct_of = 10'h1F4;
      endcase
   endfunction

   function automatic rate_centi_t rate_of(input logic [2:0] c);
      case (c)
         3'h0: rate_of = 8'h01;
         3'h1: rate_of = 8'h05;
         3'h2: rate_of = 8'h0A;
         3'h3: rate_of = 8'h0F;
         3'h4: rate_of = 8'h14;
         3'h5: rate_of = 8'h32;
         3'h6: rate_of = 8'h64;
         default: rate_of = 8'hC8;
      endcase
   endfunction

   // Reserved codes fall back to zero degrees and raise a flag.
   assign f.angle_deg      = angle_of(f.align_code);
   assign f.angle_reserved = (f.align_code > `ALIGN_LAST_VALID);
   assign f.pct_tenth      = pct_of(f.pct_code);
   assign f.rate_centi     = rate_of(f.rate_code);

endmodule

//--- hdl/motor_startup_closed_loop_cfg.sv
// Purpose: Start-up and closed-loop configuration bank with decode.
// Assumes: Register port and control inputs share clk.
// Notes:   A ramp engine shrinks the angle gap once per millisecond.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "startup_cfg_map.svh"

module motor_startup_closed_loop_cfg
   import startup_cfg_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `RAMP_STEP_NS / `CLK_PERIOD_NS
)
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic [7:0]         addr,
   input  wire logic [31:0]        wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output logic      [31:0]        rdata,
   input  wire startup_mode_t      startup_mode,
   input  wire logic [15:0]        max_speed,
   input  wire logic               gap_load,
   input  wire logic [15:0]        gap_start,
   output logic      [8:0]         align_angle_deg,
   output logic                    align_code_reserved,
   output logic      [9:0]         initial_cycle_pct,
   output logic      [15:0]        first_cycle_freq,
   output logic      [7:0]         ramp_rate,
   output logic      [15:0]        theta_gap,
   output logic                    ramp_busy,
   output logic                    overmod_on,
   output logic      [4:0]         closed_loop_accel,
   output logic                    decel_source_select,
   output logic      [4:0]         closed_loop_decel,
   output logic      [3:0]         pwm_out_freq,
   output logic                    pwm_mode,
   output logic      [1:0]         speed_pulse_select,
   output logic      [3:0]         speed_pulse_divider,
   output logic                    speed_pulse_config,
   output logic      [2:0]         speed_pulse_backemf_level,
   output logic                    surge_guard_on,
   output logic                    dead_interval_correction_on,
   output logic                    velocity_loop_off,
   output logic                    slow_recirculate_brake_on
);

   localparam int unsigned STEPS = (STEP_CYCLES < 1) ? 1 : STEP_CYCLES;

   logic [31:0]          motor_startup_settings_two;
   logic [31:0]          closed_loop_settings_one;
   logic [31:0]          next_rdata;
   logic [31:0]          status_word;
   logic                 hit_startup;
   logic                 hit_closed;
   logic                 hit_status;
   logic                 uses_select;
   logic                 freq_forced_zero;
   logic [9:0]           eff_pct;
   logic [25:0]          scaled_product;
   logic [15:0]          next_first_freq;
   logic [31:0]          step_count;
   logic                 step_tick;
   ramp_state_t          ramp_state;
   ramp_state_t          next_ramp_state;
   logic [15:0]          next_gap;
   logic [15:0]          rate_wide;

   cfg_field_if fields ();

   startup_field_decode u_decode (
      .f (fields)
   );

   // Register decode.
   assign hit_startup = (addr == `OFS_STARTUP_TWO);
   assign hit_closed  = (addr == `OFS_CLOSED_LOOP_ONE);
   assign hit_status  = (addr == `OFS_RAMP_STATUS);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         closed_loop_settings_one <= `RST_CLOSED_LOOP_ONE;
      end else if (wr && hit_closed) begin
         closed_loop_settings_one <= wdata;
      end
   end

   // The start-up word keeps all 32 bits so software reads back its writes.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         motor_startup_settings_two <= `RST_STARTUP_TWO;
      end else if (wr && hit_startup) begin
         motor_startup_settings_two <= wdata;
      end
   end

   assign status_word = {15'h0000, ramp_busy, theta_gap};

   // Unmapped addresses read as zero.
   assign next_rdata = hit_startup ? motor_startup_settings_two :
                       hit_closed  ? closed_loop_settings_one :
                       hit_status  ? status_word : 32'h0000_0000;

   // Data fall back to zero, so a stale word never looks like an answer.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   assign fields.align_code =
      motor_startup_settings_two[`ALIGN_ANGLE_MSB:`ALIGN_ANGLE_LSB];
   assign fields.pct_code =
      motor_startup_settings_two[`FIRST_PCT_MSB:`FIRST_PCT_LSB];
   assign fields.rate_code =
      motor_startup_settings_two[`RAMP_RATE_MSB:`RAMP_RATE_LSB];

   // Slow-cycle start-up always takes the percentage field.
   // Mode-gated zero frequency
   assign uses_select = (startup_mode == start_align) ||
                        (startup_mode == start_double_align) ||
                        (startup_mode == start_init_pos);
   assign freq_forced_zero = uses_select &&
                             !motor_startup_settings_two[`FIRST_SEL_BIT];
   assign eff_pct = freq_forced_zero ? 10'h000 : fields.pct_tenth;

   // The product keeps every bit; only the quotient is cut.
   // Scale by maximum speed
   assign scaled_product = max_speed * eff_pct;
   assign next_first_freq = 16'(scaled_product / `PCT_SCALE);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         align_angle_deg     <= 9'h000;
         align_code_reserved <= 1'b0;
      end else begin
         align_angle_deg     <= fields.angle_deg;
         align_code_reserved <= fields.angle_reserved;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         initial_cycle_pct <= 10'h000;
         first_cycle_freq  <= 16'h0000;
         ramp_rate         <= 8'h00;
      end else begin
         initial_cycle_pct <= fields.pct_tenth;
         first_cycle_freq  <= next_first_freq;
         ramp_rate         <= fields.rate_centi;
      end
   end

   // A free step counter avoids a divider in the ramp path.
   // Steps do not align to a load, so the first may come early.
   assign step_tick = (step_count == STEPS - 1);

   always_ff @(posedge clk) begin
      if (!nrst || step_tick) begin
         step_count <= 32'h0000_0000;
      end else begin
         step_count <= step_count + 32'h0000_0001;
      end
   end

   assign rate_wide = {8'h00, fields.rate_centi};
   assign next_gap  = (theta_gap > rate_wide) ?
                      16'(theta_gap - rate_wide) : 16'h0000;

   // A load in the hold cycle restarts the ramp at once.
   always_comb begin
      next_ramp_state = ramp_state;
      case (ramp_state)
         ramp_idle: begin
            if (gap_load) begin
               next_ramp_state = ramp_run;
            end
         end
         ramp_run: begin
            if (gap_load) begin
               next_ramp_state = ramp_run;
            end else if (step_tick && next_gap == 16'h0000) begin
               next_ramp_state = ramp_hold;
            end
         end
         ramp_hold: begin
            next_ramp_state = gap_load ? ramp_run : ramp_idle;
         end
         default: begin
            next_ramp_state = ramp_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ramp_state <= ramp_idle;
      end else begin
         ramp_state <= next_ramp_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         theta_gap <= 16'h0000;
      end else if (gap_load) begin
         theta_gap <= gap_start;
      end else if (ramp_state == ramp_run && step_tick) begin
         theta_gap <= next_gap;
      end
   end

   // Busy comes from the state register, so it cannot glitch.
   assign ramp_busy = (ramp_state == ramp_run);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         overmod_on                  <= 1'b0;
         closed_loop_accel           <= 5'h00;
         decel_source_select         <= 1'b0;
         closed_loop_decel           <= 5'h00;
      end else begin
         overmod_on          <= closed_loop_settings_one[`CL_OVERMOD_BIT];
         closed_loop_accel   <=
            closed_loop_settings_one[`CL_ACCEL_MSB:`CL_ACCEL_LSB];
         decel_source_select <= closed_loop_settings_one[`CL_DECEL_SRC_BIT];
         closed_loop_decel   <=
            closed_loop_settings_one[`CL_DECEL_MSB:`CL_DECEL_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwm_out_freq                <= 4'h0;
         pwm_mode                    <= 1'b0;
      end else begin
         pwm_out_freq        <=
            closed_loop_settings_one[`CL_PWM_FREQ_MSB:`CL_PWM_FREQ_LSB];
         pwm_mode            <= closed_loop_settings_one[`CL_PWM_MODE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         speed_pulse_select          <= 2'h0;
         speed_pulse_divider         <= 4'h0;
         speed_pulse_config          <= 1'b0;
         speed_pulse_backemf_level   <= 3'h0;
      end else begin
         speed_pulse_select        <=
            closed_loop_settings_one[`CL_SP_SEL_MSB:`CL_SP_SEL_LSB];
         speed_pulse_divider       <=
            closed_loop_settings_one[`CL_SP_DIV_MSB:`CL_SP_DIV_LSB];
         speed_pulse_config        <= closed_loop_settings_one[`CL_SP_CFG_BIT];
         speed_pulse_backemf_level <=
            closed_loop_settings_one[`CL_SP_BEMF_MSB:`CL_SP_BEMF_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         surge_guard_on              <= 1'b0;
         dead_interval_correction_on <= 1'b0;
         velocity_loop_off           <= 1'b0;
         slow_recirculate_brake_on   <= 1'b0;
      end else begin
         surge_guard_on            <= closed_loop_settings_one[`CL_SURGE_BIT];
         dead_interval_correction_on <=
            closed_loop_settings_one[`CL_DEADCOMP_BIT];
         velocity_loop_off         <=
            closed_loop_settings_one[`CL_VLOOP_OFF_BIT];
         slow_recirculate_brake_on <= closed_loop_settings_one[`CL_RECIRC_BIT];
      end
   end

endmodule

//--- test/startup_cfg_properties.sv
// Purpose: Port timing relations of the start-up and closed-loop bank.
// Assumes: One clock; shadows follow what software last wrote.
// Notes:   The bind follows the checker module.
`timescale 1ns/1ns
`include "startup_cfg_map.svh"
module startup_cfg_properties
   import startup_cfg_pkg::*;
(
   input wire logic          clk,
   input wire logic          nrst,
   input wire logic [7:0]    addr,
   input wire logic [31:0]   wdata,
   input wire logic          wr,
   input wire logic          rd,
   input wire logic [31:0]   rdata,
   input wire startup_mode_t startup_mode,
   input wire logic          gap_load,
   input wire logic [15:0]   gap_start,
   input wire logic [8:0]    align_angle_deg,
   input wire logic          align_code_reserved,
   input wire logic [15:0]   first_cycle_freq,
   input wire logic [7:0]    ramp_rate,
   input wire logic [15:0]   theta_gap,
   input wire logic          ramp_busy
);
   logic [31:0]      sh_start;
   logic [31:0]      sh_loop;
   logic [15:0]      gap_exp;
   wire logic [4:0]  al_code = sh_start[12:8];
   wire logic [2:0]  rate_code = sh_start[2:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sh_start <= 32'h0000_0000;
         sh_loop  <= 32'h0000_0000;
      end else if (wr && addr == `OFS_STARTUP_TWO) begin
         sh_start <= wdata;
      end else if (wr && addr == `OFS_CLOSED_LOOP_ONE) begin
         sh_loop <= wdata;
      end
   end
   // Floor at zero, so a rate larger than the gap cannot wrap it.
   always_ff @(posedge clk) begin
      gap_exp <= (theta_gap > 16'(ramp_rate)) ?
                 theta_gap - 16'(ramp_rate) : 16'h0000;
   end
   sequence s_loop_read;
      rd && addr == `OFS_CLOSED_LOOP_ONE;
   endsequence
   sequence s_moving;
      (ramp_busy && !gap_load) ##1 (theta_gap != $past(theta_gap));
   endsequence
   sequence s_reach_zero;
      (theta_gap != 16'h0 && !gap_load) ##1 (theta_gap == 16'h0 && !gap_load)
      ##1 !gap_load;
   endsequence
   a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_loop_read_back: assert property (
      s_loop_read |=> rdata == $past(sh_loop))
      else $error("closed-loop word read back wrong");
   a_status_view: assert property (
      rd && addr == `OFS_RAMP_STATUS |=>
      rdata == {15'h0, $past(ramp_busy), $past(theta_gap)})
      else $error("status word wrong");
   a_align_flag: assert property (
      $past(nrst) |->
      align_code_reserved == ($past(al_code) > `ALIGN_LAST_VALID))
      else $error("reserved align flag wrong");
   a_align_zero: assert property (
      align_code_reserved |-> align_angle_deg == 9'h0)
      else $error("reserved align code gave nonzero angle");
   a_rate_top: assert property (
      $past(nrst) && $past(rate_code) == 3'h7 |-> ramp_rate == 8'hC8)
      else $error("top ramp rate wrong");
   a_forced_zero: assert property (
      (startup_mode != start_slow_cycle &&
      !sh_start[`FIRST_SEL_BIT]) [*3] |-> first_cycle_freq == 16'h0)
      else $error("first cycle frequency not forced to zero");
   a_gap_load: assert property (
      gap_load |=> theta_gap == $past(gap_start) && ramp_busy)
      else $error("gap load not taken");
   a_step_exact: assert property (s_moving |-> theta_gap == gap_exp)
      else $error("gap step size wrong");
   a_busy_drop: assert property (s_reach_zero |=> !ramp_busy)
      else $error("busy stayed high after gap closed");
endmodule

bind motor_startup_closed_loop_cfg startup_cfg_properties checker_i (
   .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .startup_mode(startup_mode), .gap_load(gap_load),
   .gap_start(gap_start), .align_angle_deg(align_angle_deg),
   .align_code_reserved(align_code_reserved),
   .first_cycle_freq(first_cycle_freq), .ramp_rate(ramp_rate),
   .theta_gap(theta_gap), .ramp_busy(ramp_busy));

//--- test/tb_top.sv
// Purpose: Self-checking bench for the start-up and closed-loop bank.
// Assumes: Ramp step shortened to 10 cycles.
// Notes:   Decoded outputs are sampled a few cycles after each write.
`timescale 1ns/1ns
module tb_top;
   import startup_cfg_pkg::*;
   localparam int STEP = 10;
   localparam int ang_tab [29] = '{0, 10, 20, 30, 45, 60, 70, 80, 90, 110,
      120, 135, 150, 160, 170, 180, 190, 210, 225, 240, 250, 260, 270, 280,
      290, 315, 330, 340, 350};
   localparam int pct_tab [16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175,
      200, 250, 300, 350, 400, 450, 500};
   localparam int rate_tab [8] = '{1, 5, 10, 15, 20, 50, 100, 200};
   localparam logic [31:0] cl_pat [4] = '{32'hFFFF_FFFF, 32'h8000_0000,
      32'hA5C3_0F96, 32'h0000_0000};
   logic          clk, nrst, wr, rd, gap_load, align_code_reserved, ramp_busy;
   logic [7:0]    addr, ramp_rate;
   logic [31:0]   wdata, rdata, got;
   startup_mode_t startup_mode;
   logic [15:0]   max_speed, gap_start, theta_gap, first_cycle_freq;
   logic [8:0]    align_angle_deg;
   logic [9:0]    initial_cycle_pct;
   logic [30:0]   cl_fields;
   int            n_errors, n_compared, cycles, n;

   motor_startup_closed_loop_cfg #(.STEP_CYCLES(STEP))
      motor_startup_closed_loop_cfg_i (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .startup_mode(startup_mode), .max_speed(max_speed),
      .gap_load(gap_load), .gap_start(gap_start),
      .align_angle_deg(align_angle_deg),
      .align_code_reserved(align_code_reserved),
      .initial_cycle_pct(initial_cycle_pct),
      .first_cycle_freq(first_cycle_freq), .ramp_rate(ramp_rate),
      .theta_gap(theta_gap), .ramp_busy(ramp_busy),
      .overmod_on(cl_fields[30]), .closed_loop_accel(cl_fields[29:25]),
      .decel_source_select(cl_fields[24]),
      .closed_loop_decel(cl_fields[23:19]), .pwm_out_freq(cl_fields[18:15]),
      .pwm_mode(cl_fields[14]), .speed_pulse_select(cl_fields[13:12]),
      .speed_pulse_divider(cl_fields[11:8]),
      .speed_pulse_config(cl_fields[7]),
      .speed_pulse_backemf_level(cl_fields[6:4]),
      .surge_guard_on(cl_fields[3]),
      .dead_interval_correction_on(cl_fields[2]),
      .velocity_loop_off(cl_fields[1]),
      .slow_recirculate_brake_on(cl_fields[0]));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, seen);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic test_reset();
      reg_rd(8'h88, got);
      check("loop word reset", 32'h0, got);
      reg_rd(8'h84, got);
      check("start word reset", 32'h0, got);
      check("loop fields reset", 32'h0, {1'b0, cl_fields});
      $display("test_reset done");
   endtask

   task automatic test_loop_word();
      foreach (cl_pat[i]) begin
         reg_wr(8'h88, cl_pat[i]);
         reg_rd(8'h88, got);
         check("loop word", cl_pat[i], got);
         settle();
         check("loop fields", {1'b0, cl_pat[i][30:0]},
               {1'b0, cl_fields});
      end
      $display("test_loop_word done");
   endtask

   // Reserved codes are swept too, to see the flag and the zero angle.
   task automatic test_align();
      for (int c = 0; c < 32; c++) begin
         reg_wr(8'h84, 32'(c) << 8);
         settle();
         check("align angle",
               (c <= 28) ? ang_tab[c] : 0, 32'(align_angle_deg));
         check("align reserved",
               32'(c > 28), 32'(align_code_reserved));
      end
      $display("test_align done");
   endtask

   task automatic test_pct_rate();
      for (int c = 0; c < 16; c++) begin
         reg_wr(8'h84, (32'(c) << 4) | 32'(c & 7));
         settle();
         check("first pct", pct_tab[c], 32'(initial_cycle_pct));
         check("first freq",
               2000 * pct_tab[c] / 1000, 32'(first_cycle_freq));
         check("ramp rate", rate_tab[c & 7], 32'(ramp_rate));
      end
      $display("test_pct_rate done");
   endtask

   task automatic test_select();
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         startup_mode <= startup_mode_t'(m);
         for (int s = 0; s < 2; s++) begin
            reg_wr(8'h84, 32'h0000_00F0 | (32'(s) << 3));
            settle();
            check("select freq",
                  (m == 0 || s == 1) ? 1000 : 0, 32'(first_cycle_freq));
         end
      end
      $display("test_select done");
   endtask

   // Gap 300 at rate 200 closes in two ticks of an unaligned step counter.
   task automatic test_ramp();
      reg_wr(8'h84, 32'h0000_0007);
      settle();
      @(posedge clk);
      gap_start <= 16'd300;
      gap_load  <= 1'b1;
      @(posedge clk);
      gap_load <= 1'b0;
      #1;
      check("busy after load", 32'h1, 32'(ramp_busy));
      check("gap after load", 32'd300, 32'(theta_gap));
      n = 0;
      while (ramp_busy === 1'b1 && n < 100) begin
         @(posedge clk);
         #1 n++;
      end
      check("ramp length",
            32'h1, 32'(n >= STEP + 1 && n <= 2 * STEP + 2));
      reg_rd(8'h8C, got);
      check("status idle", 32'h0, got);
      $display("test_ramp done");
   endtask

   task automatic test_refused();
      reg_wr(8'h8C, 32'hFFFF_FFFF);
      reg_wr(8'h40, 32'h1234_5678);
      reg_rd(8'h40, got);
      check("unmapped read", 32'h0, got);
      reg_rd(8'h88, got);
      check("loop word kept", 32'h0, got);
      $display("test_refused done");
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      startup_mode = start_slow_cycle;
      max_speed = 16'd2000;
      gap_load = 1'b0;
      gap_start = 16'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      test_reset();
      test_loop_word();
      test_align();
      test_pct_rate();
      test_select();
      test_ramp();
      test_refused();
      give_verdict();
   end
endmodule
